/* pkg/status_reg_map.vh */
// Opcodes, bit positions and reset values of the status register block.
`ifndef STATUS_REG_MAP_VH
`define STATUS_REG_MAP_VH
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_STATUS2 8'h31
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_BYTE_PROGRAM 8'h02
`define OP_OTP_PROGRAM 8'h9b
`define OP_BLOCK_ERASE4 8'h20
`define OP_BLOCK_ERASE32 8'h52
`define OP_PAGE_ERASE 8'h81
`define OP_CHIP_ERASE 8'h60
`define OP_CHIP_ERASE_ALT 8'hc7
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define SR1_LOCK_BIT 7
`define SR1_ERROR_BIT 5
`define SR1_PIN_BIT 4
`define SR1_PROT_BIT 2
`define SR1_WEL_BIT 1
`define SR_BUSY_BIT 0
`define SR2_RESET_CMD_ENABLE_BIT 4
`define BIT_CNT_W 4
`define BIT_CNT_OPCODE 4'h8
`define BIT_CNT_DATA 4'h8
`define BIT_CNT_LAST 4'hf
`define BIT_IDX_TOP 3'h7
`define RST_BIT 1'b0
`define RST_BYTE 8'h00
`define RST_CNT 4'h0
`define BIT_SEL_BYTE 3
`endif

/* logic/pin_sync.v */
// Two-stage synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input wire clk_sys, // System clock.
	input wire rst_n, // Asynchronous reset, active low.
	input wire [WIDTH-1:0] din, // Asynchronous inputs.
	output reg [WIDTH-1:0] dout // Synchronised outputs.
);
	reg [WIDTH-1:0] meta_ff;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= INIT;
			dout <= INIT;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule

/* logic/flash_status_reg.v */
// Serial flash status register with read-status and write-status command handling.
`timescale 1ns/1ns
`include "status_reg_map.vh"

// Notes on behaviour
// RL1: Opcode 05h starts status output next clock.
// RL2: Byte one then byte two, MSB first, repeating.
// RL3: Every repetition samples live status bits.
// RL4: Read status allowed even while busy.
// RL5: Chip select high ends read, output floats.
// RL6: Byte one: lock, error, pin, protect, WRITE_ENABLE_LATCH, busy.
// RL7: Write status changes only bits 7 and 2.
// RL8: Lock plus asserted pin freezes protect bit.
// RL9: Lock resets to zero; protect then free.
// RL10: Pin asserted: lock may only be set.
// RL11: Error set when a byte failed.
// RL12: Aborted operations never set error.
// RL13: Error refreshed after each program or erase.
// RL14: Pin mirror reads 0 when pin asserted.
// RL15: Protect bit rejects program and erase.
// RL16: Cleared WRITE_ENABLE_LATCH refuses writes, erases, OTP, status.
// RL17: WRITE_ENABLE_LATCH cleared at power-up and reset.
// RL18: WRITE_ENABLE_LATCH cleared on write ops complete or abort.
// RL19: Partial or unknown opcode keeps WRITE_ENABLE_LATCH.
// RL20: Busy bit at bit 0 of both bytes.
// RL21: Host polls until busy goes low.
// RL22: Reserved bits 6 and 3 read zero.
// RL23: Byte two: reset enable bit 4, busy.
// RL24: Write status 01h, data lock bit7 protect bit2.
// RL25: Output shifts on falling serial clock.
module flash_status_reg (
	input wire clk_sys, // System clock, 100 MHz.
	input wire rst_n, // Asynchronous power-up reset, active low.
	input wire cs_n, // Chip select pin, active low.
	input wire sck, // Serial clock pin from the host.
	input wire si, // Serial data in pin.
	output reg so_o, // Serial data out value.
	output reg so_oe, // Serial data out enable, high while driving.
	input wire wp_n, // Write-protect pin, active low.
	input wire dev_reset, // Device reset operation pulse, clk_sys domain.
	input wire op_busy, // Internal self-timed operation in progress.
	input wire op_done, // Program or erase finished, one-cycle pulse.
	input wire op_fail, // With op_done: at least one byte failed.
	input wire op_abort, // Program, erase or OTP aborted, one-cycle pulse.
	input wire hold_abort, // Hold condition aborted, one-cycle pulse.
	output reg protect_lock, // Lock bit.
	output reg array_protect, // Array protected, rejects program and erase.
	output reg write_enable_latch, // Write-enable latch.
	output reg erase_program_error, // Error flag of last program or erase.
	output reg reset_cmd_enable, // Reset command enabled.
	output reg write_allowed, // High when program or erase may start.
	output reg cmd_start, // Pulse: full opcode received (writes gated).
	output reg [7:0] cmd_opcode // Opcode of the current frame.
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_DATA = 4'b0010;
	localparam ST_STATUS = 4'b0100;
	localparam ST_IGNORE = 4'b1000;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers. Each pin gets its own pair of flip-flops, and each
	// starts at the idle level of its pin so that no false edge follows reset.
	wire cs_s;
	wire sck_s;
	wire si_s;
	wire wp_s;

	pin_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_cs (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(cs_n),
		.dout(cs_s)
	);

	pin_sync #(.WIDTH(1), .INIT(`RST_BIT)) u_sync_sck (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(sck),
		.dout(sck_s)
	);

	pin_sync #(.WIDTH(1), .INIT(`RST_BIT)) u_sync_si (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(si),
		.dout(si_s)
	);

	pin_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_wp (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(wp_n),
		.dout(wp_s)
	);

	reg sck_d_ff;
	reg cs_d_ff;
	wire sck_rise = sck_s & ~sck_d_ff & ~cs_s;
	wire sck_fall = ~sck_s & sck_d_ff & ~cs_s;
	wire cs_rise = cs_s & ~cs_d_ff;

	// Delayed copies for edge detection, reset to the idle level of each pin.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sck_d_ff <= `RST_BIT;
			cs_d_ff <= 1'b1;
		end else begin
			sck_d_ff <= sck_s;
			cs_d_ff <= cs_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame decoder.
	// One command per chip-select frame. The opcode is taken at the eighth
	// rising serial clock; write-status frames then collect one data byte,
	// read-status frames stream status bits, and anything else is ignored
	// until chip select rises again.
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [7:0] shift_ff;
	reg [`BIT_CNT_W-1:0] bit_cnt_ff;
	reg [7:0] data_ff;
	reg data_full_ff;
	reg [`BIT_CNT_W-1:0] out_cnt_ff;

	wire [7:0] shifted = {shift_ff[6:0], si_s};
	wire op_full = sck_rise && (state_ff == ST_IDLE) && (bit_cnt_ff == `BIT_CNT_OPCODE - 4'h1);
	wire data_full = sck_rise && (state_ff == ST_DATA) && (bit_cnt_ff == `BIT_CNT_LAST);

	// Commands that need the write-enable latch and clear it when they end.
	// Write status is handled on its own because it also carries data.
	function is_write_op;
		input [7:0] op;
		begin
			case (op)
				`OP_BYTE_PROGRAM, `OP_OTP_PROGRAM, `OP_BLOCK_ERASE4, `OP_BLOCK_ERASE32,
				`OP_PAGE_ERASE, `OP_CHIP_ERASE, `OP_CHIP_ERASE_ALT: is_write_op = 1'b1;
				default: is_write_op = 1'b0;
			endcase
		end
	endfunction

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (op_full) begin
					if (shifted == `OP_READ_STATUS)
						nxt_state = ST_STATUS; // RL1 RL4
					else if (shifted == `OP_WRITE_STATUS || shifted == `OP_WRITE_STATUS2)
						nxt_state = ST_DATA;
					else
						nxt_state = ST_IGNORE;
				end
			end
			ST_DATA: begin
				if (data_full)
					nxt_state = ST_IGNORE;
			end
			ST_STATUS: nxt_state = ST_STATUS;
			ST_IGNORE: nxt_state = ST_IGNORE;
			default: nxt_state = ST_IDLE;
		endcase
		if (cs_s)
			nxt_state = ST_IDLE; // RL5
	end

	// Status bytes assembled from live state each time a bit is picked.
	// No snapshot is taken at the start of the command, so a host that keeps
	// clocking sees the busy bit fall at the next bit 0 of either byte once the operation ends.
	// The out counter walks byte one bits 7 to 0, then byte two, and its
	// natural wrap repeats the pair for as long as chip select stays low.
	wire [7:0] status_one = {protect_lock, 1'b0, erase_program_error, wp_s, 1'b0,
		array_protect, write_enable_latch, op_busy}; // RL6 RL14 RL22 RL20
	wire [7:0] status_two = {3'h0, reset_cmd_enable, 3'h0, op_busy}; // RL23 RL20
	wire [7:0] cur_byte = out_cnt_ff[`BIT_SEL_BYTE] ? status_two : status_one; // RL2
	wire cur_bit = cur_byte[`BIT_IDX_TOP - out_cnt_ff[2:0]]; // RL3

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			shift_ff <= `RST_BYTE;
			bit_cnt_ff <= `RST_CNT;
			data_ff <= `RST_BYTE;
			data_full_ff <= `RST_BIT;
			out_cnt_ff <= `RST_CNT;
			so_o <= `RST_BIT;
			so_oe <= `RST_BIT;
			cmd_start <= `RST_BIT;
			cmd_opcode <= `RST_BYTE;
		end else begin
			state_ff <= nxt_state;
			cmd_start <= `RST_BIT;
			// Chip select high ends any frame at once, mid-byte included, and
			// releases the output line.
			if (cs_s) begin
				bit_cnt_ff <= `RST_CNT;
				data_full_ff <= `RST_BIT;
				out_cnt_ff <= `RST_CNT;
				so_oe <= `RST_BIT; // RL5
			end else if (sck_rise) begin
				shift_ff <= shifted;
				// After the opcode the counter wraps back to the opcode length,
				// so it sits on that value at every byte boundary.
				if (bit_cnt_ff != `BIT_CNT_LAST)
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				else
					bit_cnt_ff <= `BIT_CNT_OPCODE;
				if (data_full) begin
					data_ff <= shifted;
					data_full_ff <= 1'b1;
				end else if (state_ff == ST_IGNORE && data_full_ff) begin
					data_full_ff <= 1'b1;
				end
				if (state_ff == ST_DATA && bit_cnt_ff != `RST_CNT && !data_full)
					data_full_ff <= `RST_BIT;
				// Program and erase starts are withheld while the latch is clear.
				if (op_full) begin
					cmd_opcode <= shifted;
					cmd_start <= write_enable_latch | ~is_write_op(shifted); // RL16
				end
			end else if (sck_fall && state_ff == ST_STATUS) begin
				so_oe <= 1'b1; // RL25
				so_o <= cur_bit; // RL2 RL3
				out_cnt_ff <= out_cnt_ff + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status bits.
	// The registered status bits change only at the end of a frame or on an operation
	// pulse, and such a pulse can arrive while a status byte is being shifted out.
	// Frame ended on a byte boundary after the full data byte.
	wire on_byte_edge = (bit_cnt_ff == `BIT_CNT_OPCODE);
	wire ws_full = cs_rise && data_full_ff && on_byte_edge;
	wire is_ws = (cmd_opcode == `OP_WRITE_STATUS);
	wire is_ws2 = (cmd_opcode == `OP_WRITE_STATUS2);
	wire frame_had_op = cs_rise && (state_ff != ST_IDLE);
	wire ws_end = frame_had_op && (is_ws || is_ws2);
	wire ws_ok = ws_end && ws_full && write_enable_latch; // RL16
	wire lock_nxt = data_ff[`SR1_LOCK_BIT];
	wire prot_nxt = data_ff[`SR1_PROT_BIT];
	wire wp_on = ~wp_s;
	wire ws_ignored = wp_on && protect_lock && !lock_nxt; // RL10
	wire ws_apply = ws_ok && is_ws && !ws_ignored;
	wire wr_op_end = frame_had_op && is_write_op(cmd_opcode);
	// Lock set and pin asserted freeze the protect bit where it stands.
	wire prot_frozen = protect_lock && wp_on;
	// Sources that clear the latch regardless of the frame in progress.
	wire wel_hw_clear = dev_reset | op_done | op_abort | hold_abort;
	// Frame ends decoded from the opcode of the frame that just closed.
	wire wel_wd_end = frame_had_op && (cmd_opcode == `OP_WRITE_DISABLE);
	wire wel_we_end = frame_had_op && (cmd_opcode == `OP_WRITE_ENABLE);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			protect_lock <= `RST_BIT; // RL9
			array_protect <= `RST_BIT;
			write_enable_latch <= `RST_BIT; // RL17
			erase_program_error <= `RST_BIT;
			reset_cmd_enable <= `RST_BIT;
			write_allowed <= `RST_BIT;
		end else begin
			write_allowed <= write_enable_latch & ~array_protect; // RL15 RL16
			if (ws_apply) begin
				protect_lock <= lock_nxt; // RL7 RL24
				if (!prot_frozen)
					array_protect <= prot_nxt; // RL8 RL9
			end
			if (ws_ok && is_ws2)
				reset_cmd_enable <= data_ff[`SR2_RESET_CMD_ENABLE_BIT];
			if (op_done)
				erase_program_error <= op_fail; // RL11 RL13 RL12
			// Set by write enable; write ops and aborts clear, and any clear wins over a set in the same cycle.
			if (dev_reset)
				write_enable_latch <= `RST_BIT; // RL17
			else if (wel_hw_clear)
				write_enable_latch <= `RST_BIT; // RL18
			else if (ws_end)
				write_enable_latch <= `RST_BIT; // RL18
			else if (wr_op_end && !write_enable_latch)
				write_enable_latch <= `RST_BIT; // RL19
			else if (wel_wd_end)
				write_enable_latch <= `RST_BIT; // RL18
			else if (wel_we_end)
				write_enable_latch <= 1'b1;
		end
	end
endmodule

/* test/flash_status_reg_monitor.sv */
// Port-level checks of the status register block.
`timescale 1ns/1ns
module flash_status_reg_monitor (
	input wire clk_sys, // Clock.
	input wire rst_n, // Reset.
	input wire cs_n, // Select.
	input wire wp_n, // Protect pin.
	input wire dev_reset, // Reset op.
	input wire op_done, // Done.
	input wire op_fail, // Failed.
	input wire op_abort, // Abort.
	input wire hold_abort, // Hold abort.
	input wire so_oe, // Out enable.
	input wire protect_lock, // Lock.
	input wire array_protect, // Protect.
	input wire write_enable_latch, // Latch.
	input wire erase_program_error, // Error.
	input wire write_allowed // Gate.
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_oe_release: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
		else $error("output still driven");
	a_err_load: assert property (
		op_done |=> erase_program_error == $past(op_fail)) else $error("error flag wrong");
	a_abort_keeps: assert property (
		op_abort |=> !write_enable_latch && $stable(erase_program_error)) else $error("abort");
	a_done_clears: assert property (op_done |=> !write_enable_latch)
		else $error("latch kept after done");
	a_reset_clears: assert property ((dev_reset || hold_abort) |=> !write_enable_latch)
		else $error("latch kept after reset");
	a_gate_follows: assert property (
		write_allowed == $past(write_enable_latch && !array_protect)) else $error("gate");
	a_lock_holds: assert property ((!wp_n && protect_lock) [*4] |=> protect_lock)
		else $error("lock cleared");
	a_prot_frozen: assert property (
		(!wp_n && protect_lock) [*4] |=> $stable(array_protect)) else $error("protect moved");
endmodule
bind flash_status_reg flash_status_reg_monitor i_mon (.*);

/* test/spi_host.sv */
// Host serial controller model that frames commands and samples the status stream.
`timescale 1ns/1ns
module spi_host (
	input wire clk_sys, // Pacing clock.
	input wire so_o, // Serial out value.
	input wire so_oe, // Serial out enable.
	output reg cs_n = 1'b1, // Chip select, active low.
	output reg sck = 1'b0, // Serial clock, idle low.
	output reg si = 1'b0 // Serial data in.
);
	task automatic frame(input [15:0] tx, input int nb, output [15:0] st);
		logic [15:0] sh;
		sh = tx;
		st = 16'h0000;
		@(posedge clk_sys);
		cs_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			si <= sh[15];
			sh = {sh[14:0], 1'b0};
			repeat (6) @(posedge clk_sys);
			st = {st[14:0], so_oe ? so_o : 1'bz};
			sck <= 1'b1;
			repeat (7) @(posedge clk_sys);
			sck <= 1'b0;
		end
		repeat (6) @(posedge clk_sys);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule

/* test/flash_status_reg_bench.sv */
// Self-checking bench of the status register block.
`timescale 1ns/1ns
`include "status_reg_map.vh"
`define chk(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module flash_status_reg_bench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic dev_reset = 1'b0;
	logic op_busy = 1'b0;
	logic op_done = 1'b0;
	logic op_fail = 1'b0;
	logic op_abort = 1'b0;
	logic hold_abort = 1'b0;
	wire cs_n, sck, si, so_o, so_oe, protect_lock, array_protect, write_enable_latch;
	wire erase_program_error, reset_cmd_enable, write_allowed, cmd_start;
	wire [7:0] cmd_opcode;
	int miscompares = 0;
	int check_count = 0;
	flash_status_reg i_flash_status_reg (.*);
	spi_host i_spi_host (.clk_sys(clk_sys), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n),
		.sck(sck), .si(si));
	function automatic [15:0] ex(input lk, er, pr, we, bz);
		ex = {lk, 1'b0, er, wp_n, 1'b0, pr, we, bz, 7'h00, bz};
	endfunction
	task automatic cmd(input [7:0] op, input [7:0] d, input int nb);
		logic [15:0] st;
		i_spi_host.frame({op, d}, nb, st);
	endtask
	task automatic rd(input [15:0] e);
		logic [15:0] st;
		i_spi_host.frame({`OP_READ_STATUS, 8'h00}, 24, st);
		`chk(st, e)
		`chk(so_oe, 1'b0)
	endtask
	task automatic pulse(input int k, input f);
		@(posedge clk_sys);
		op_fail <= f;
		op_done <= (k == 0);
		op_abort <= (k == 1);
		hold_abort <= (k == 2);
		dev_reset <= (k == 3);
		@(posedge clk_sys);
		{op_done, op_abort, hold_abort, dev_reset} <= 4'h0;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic summarize();
		$display("checks %0d, miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (30000) @(posedge clk_sys);
		miscompares++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(ex(0, 0, 0, 0, 0));
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		op_busy <= 1'b1;
		rd(ex(0, 0, 0, 1, 1));
		op_busy <= 1'b0;
		cmd(`OP_WRITE_STATUS, 8'hff, 16);
		rd(ex(1, 0, 1, 0, 0));
		wp_n <= 1'b0;
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		cmd(`OP_WRITE_STATUS, 8'h00, 16);
		rd(ex(1, 0, 1, 0, 0));
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		cmd(`OP_WRITE_STATUS, 8'h80, 16);
		rd(ex(1, 0, 1, 0, 0));
		wp_n <= 1'b1;
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		cmd(`OP_WRITE_STATUS, 8'h00, 16);
		rd(ex(0, 0, 0, 0, 0));
		cmd(`OP_WRITE_STATUS, 8'h84, 16);
		rd(ex(0, 0, 0, 0, 0));
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		cmd(`OP_BYTE_PROGRAM, 8'h00, 4);
		cmd(8'h3c, 8'h00, 8);
		`chk(cmd_opcode, 8'h3c)
		rd(ex(0, 0, 0, 1, 0));
		pulse(1, 1'b0);
		rd(ex(0, 0, 0, 0, 0));
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		pulse(0, 1'b1);
		rd(ex(0, 1, 0, 0, 0));
		pulse(0, 1'b0);
		rd(ex(0, 0, 0, 0, 0));
		for (int k = 2; k < 5; k++) begin
			cmd(`OP_WRITE_ENABLE, 8'h00, 8);
			if (k < 4) pulse(k, 1'b0);
			else cmd(`OP_WRITE_DISABLE, 8'h00, 8);
			rd(ex(0, 0, 0, 0, 0));
		end
		op_busy <= 1'b1;
		fork
			rd(ex(0, 0, 0, 0, 1) & 16'hfffe);
			begin
				repeat (260) @(posedge clk_sys);
				op_busy <= 1'b0;
			end
		join
		cmd(`OP_WRITE_ENABLE, 8'h00, 8);
		cmd(`OP_WRITE_STATUS2, 8'h10, 16);
		`chk(reset_cmd_enable, 1'b1)
		rd(ex(0, 0, 0, 0, 0) | 16'h0010);
		summarize();
	end
endmodule
